// [design/dicfg_top.sv]
// Configuration and latch logic for digital inputs nine and ten
//
// Our own choices: the strobed register port and the address map.
`timescale 1ns/10ps
`include "dicfg_cfg.svh"
module dicfg_top (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  // Register port
  input  wire dicfg_pkg::dicfg_req_t bus_req,
  output logic [15:0]               rdata,
  // Field inputs
  input  wire logic                 digital_input_nine,
  input  wire logic                 digital_input_ten,
  // Conditioned results
  output dicfg_pkg::dicfg_out_t     din_out
);
  import dicfg_pkg::*;

  // Stored setting words
  logic [15:0] input9_setting_one_reg;
  logic [15:0] input9_setting_two_reg;
  logic [15:0] input10_setting_one_reg;
  logic [15:0] input10_setting_two_reg;
  logic [15:0] rdata_next;
  logic [15:0] status_word;

  // Decoded write strobes
  logic        wr_in9_pol;
  logic        wr_in9_func;
  logic        wr_in10_pol;
  logic        wr_in10_func;

  // Decoded setting fields
  logic [1:0]  pol;
  logic [1:0]  mode;
  logic [1:0]  edge_sel;
  logic [1:0]  latch_en;

  // Typed per-channel fields
  dicfg_mode_t mode9;
  dicfg_mode_t mode10;
  dicfg_edge_t edge9;
  dicfg_edge_t edge10;

  // Input conditioning
  logic [1:0]  sync1_reg;
  logic [1:0]  sync2_reg;
  logic [1:0]  adj;
  logic [1:0]  prev_reg;
  logic [1:0]  level_reg;
  logic [1:0]  level_next;
  logic [1:0]  latch_reg;
  logic [1:0]  latch_next;

  // Address match; shared by write strobes
  function automatic logic addr_hit(input logic [3:0] addr, input logic [3:0] ofs);
    addr_hit = (addr == ofs);
  endfunction

  // One bit of a setting word, picked by field position
  function automatic logic digit_bit(input logic [15:0] word, input int pos);
    digit_bit = word[pos];
  endfunction

  // Polarity applied per channel
  function automatic logic apply_pol(input logic in_bit, input logic inv);
    apply_pol = in_bit ^ inv;
  endfunction

  // One-cycle edge test against the previous adjusted level
  function automatic logic edge_hit(input logic cur, input logic last, input dicfg_edge_t sel);
    if (sel == DICFG_EDGE_RISE) begin
      edge_hit = cur & ~last;
    end else begin
      edge_hit = ~cur & last;
    end
  endfunction

  // Plain level only while the channel is a digital input
  function automatic logic plain_level(input logic cur, input dicfg_mode_t md);
    plain_level = (md == DICFG_MODE_PLAIN) ? cur : 1'b0;
  endfunction

  // Register read mux; unmapped offsets read as a fixed value
  function automatic logic [15:0] read_word(
    input logic [3:0]  addr,
    input logic [15:0] w9a,
    input logic [15:0] w9b,
    input logic [15:0] w10a,
    input logic [15:0] w10b,
    input logic [15:0] status
  );
    case (addr)
      `DICFG_OFS_IN9_POL:   read_word = w9a;
      `DICFG_OFS_IN9_FUNC:  read_word = w9b;
      `DICFG_OFS_IN10_POL:  read_word = w10a;
      `DICFG_OFS_IN10_FUNC: read_word = w10b;
      `DICFG_OFS_STATUS:    read_word = status;
      default:              read_word = `DICFG_UNMAPPED_VAL;
    endcase
  endfunction

  // Write strobes; status offset is read-only
  assign wr_in9_pol   = bus_req.wr & addr_hit(bus_req.addr, `DICFG_OFS_IN9_POL);
  assign wr_in9_func  = bus_req.wr & addr_hit(bus_req.addr, `DICFG_OFS_IN9_FUNC);
  assign wr_in10_pol  = bus_req.wr & addr_hit(bus_req.addr, `DICFG_OFS_IN10_POL);
  assign wr_in10_func = bus_req.wr & addr_hit(bus_req.addr, `DICFG_OFS_IN10_FUNC);

  // Whole words stored; reserved digits are software's to keep at zero
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      input9_setting_one_reg <= `DICFG_RESET_VAL;
    end else if (wr_in9_pol) begin
      input9_setting_one_reg <= bus_req.wdata;
    end
  end

  // Channel nine function word
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      input9_setting_two_reg <= `DICFG_RESET_VAL;
    end else if (wr_in9_func) begin
      input9_setting_two_reg <= bus_req.wdata;
    end
  end

  // Channel ten polarity word
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      input10_setting_one_reg <= `DICFG_RESET_VAL;
    end else if (wr_in10_pol) begin
      input10_setting_one_reg <= bus_req.wdata;
    end
  end

  // Channel ten function word
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      input10_setting_two_reg <= `DICFG_RESET_VAL;
    end else if (wr_in10_func) begin
      input10_setting_two_reg <= bus_req.wdata;
    end
  end

  // Status view of both channels
  assign status_word = {12'h000, latch_reg, level_reg};

  // Read data valid only in the cycle after the strobe, zero otherwise
  always_comb begin
    rdata_next = 16'h0000;
    if (bus_req.rd) begin
      rdata_next = read_word(bus_req.addr, input9_setting_one_reg, input9_setting_two_reg,
                             input10_setting_one_reg, input10_setting_two_reg, status_word);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata <= 16'h0000;
    end else begin
      rdata <= rdata_next;
    end
  end

  // Field decode
  assign pol[0]      = digit_bit(input9_setting_one_reg, `DICFG_POL_BIT);
  assign pol[1]      = digit_bit(input10_setting_one_reg, `DICFG_POL_BIT);
  assign mode[0]     = digit_bit(input9_setting_two_reg, `DICFG_FUNC_BIT);
  assign mode[1]     = digit_bit(input10_setting_two_reg, `DICFG_FUNC_BIT);
  assign edge_sel[0] = digit_bit(input9_setting_two_reg, `DICFG_EDGE_BIT);
  assign edge_sel[1] = digit_bit(input10_setting_two_reg, `DICFG_EDGE_BIT);

  // Typed views of the function digits
  assign mode9  = dicfg_mode_t'(mode[0]);
  assign mode10 = dicfg_mode_t'(mode[1]);
  assign edge9  = dicfg_edge_t'(edge_sel[0]);
  assign edge10 = dicfg_edge_t'(edge_sel[1]);

  // Latch path enabled only in timing latch mode
  assign latch_en[0] = (mode9 == DICFG_MODE_LATCH);
  assign latch_en[1] = (mode10 == DICFG_MODE_LATCH);

  // Two-stage synchroniser, channel nine; first stage feeds only the second
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync1_reg[0] <= 1'b0;
      sync2_reg[0] <= 1'b0;
    end else begin
      sync1_reg[0] <= digital_input_nine;
      sync2_reg[0] <= sync1_reg[0];
    end
  end

  // Two-stage synchroniser, channel ten
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync1_reg[1] <= 1'b0;
      sync2_reg[1] <= 1'b0;
    end else begin
      sync1_reg[1] <= digital_input_ten;
      sync2_reg[1] <= sync1_reg[1];
    end
  end

  // Inversion happens ahead of both level and edge paths
  always_comb begin
    adj[0] = apply_pol(sync2_reg[0], pol[0]);
  end

  always_comb begin
    adj[1] = apply_pol(sync2_reg[1], pol[1]);
  end

  // Edge detect, channel nine; a polarity change can itself look like an edge
  always_comb begin
    latch_next[0] = 1'b0;
    if (latch_en[0]) begin
      latch_next[0] = edge_hit(adj[0], prev_reg[0], edge9);
    end
  end

  // Edge detect, channel ten
  always_comb begin
    latch_next[1] = 1'b0;
    if (latch_en[1]) begin
      latch_next[1] = edge_hit(adj[1], prev_reg[1], edge10);
    end
  end

  // Plain level shown only in digital input mode
  always_comb begin
    level_next[0] = plain_level(adj[0], mode9);
  end

  always_comb begin
    level_next[1] = plain_level(adj[1], mode10);
  end

  // Previous adjusted level, channel nine
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prev_reg[0] <= 1'b0;
    end else begin
      prev_reg[0] <= adj[0];
    end
  end

  // Previous adjusted level, channel ten
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prev_reg[1] <= 1'b0;
    end else begin
      prev_reg[1] <= adj[1];
    end
  end

  // Latch strobe, channel nine
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      latch_reg[0] <= 1'b0;
    end else begin
      latch_reg[0] <= latch_next[0];
    end
  end

  // Latch strobe, channel ten
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      latch_reg[1] <= 1'b0;
    end else begin
      latch_reg[1] <= latch_next[1];
    end
  end

  // Level, channel nine
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      level_reg[0] <= 1'b0;
    end else begin
      level_reg[0] <= level_next[0];
    end
  end

  // Level, channel ten
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      level_reg[1] <= 1'b0;
    end else begin
      level_reg[1] <= level_next[1];
    end
  end

  // Outputs straight from flip-flops
  assign din_out.level = level_reg;
  assign din_out.latch = latch_reg;
endmodule // dicfg_top

// [design/dicfg_cfg.svh]
// Constants for the two-channel digital input configuration block
`ifndef DICFG_CFG_SVH
`define DICFG_CFG_SVH
`define DICFG_ADDR_W          4
`define DICFG_DATA_W          16
`define DICFG_OFS_IN9_POL     4'h0
`define DICFG_OFS_IN9_FUNC    4'h1
`define DICFG_OFS_IN10_POL    4'h2
`define DICFG_OFS_IN10_FUNC   4'h3
`define DICFG_OFS_STATUS      4'h4
`define DICFG_POL_BIT         0
`define DICFG_FUNC_BIT        0
`define DICFG_EDGE_BIT        4
`define DICFG_RESET_VAL       16'h0000
`define DICFG_UNMAPPED_VAL    16'h0000
`endif

// [design/dicfg_pkg.sv]
// Types for the two-channel digital input configuration block
package dicfg_pkg;
  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } dicfg_req_t;
  typedef enum logic [0:0] {
    DICFG_MODE_PLAIN = 1'b0,
    DICFG_MODE_LATCH = 1'b1
  } dicfg_mode_t;
  typedef enum logic [0:0] {
    DICFG_EDGE_RISE = 1'b0,
    DICFG_EDGE_FALL = 1'b1
  } dicfg_edge_t;
  typedef struct packed {
    logic [1:0] level;
    logic [1:0] latch;
  } dicfg_out_t;
endpackage

// [tb/dicfg_monitor.sv]
// Checker of the input configuration block
`timescale 1ns/10ps
module dicfg_monitor (
  input wire logic clk,
  input wire logic sys_rst,
  input wire dicfg_pkg::dicfg_req_t bus_req,
  input wire logic [15:0] rdata,
  input wire logic digital_input_nine,
  input wire logic digital_input_ten,
  input wire dicfg_pkg::dicfg_out_t din_out
);
  import dicfg_pkg::*;
  // Shadow of channel nine setup
  logic p, m, e;
  always_ff @(posedge clk) begin
    if (sys_rst) {p, m, e} <= 3'b000;
    else if (bus_req.wr && bus_req.addr == 4'h0) p <= bus_req.wdata[0];
    else if (bus_req.wr && bus_req.addr == 4'h1) {e, m} <= {bus_req.wdata[4], bus_req.wdata[0]};
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  AST_RST: assert property (disable iff (1'b0) sys_rst |=> rdata == 16'h0000 && din_out == 4'h0)
    else $error("reset");
  AST_PULSE: assert property (din_out.latch[0] |=> !din_out.latch[0]) else $error("pulse");
  AST_MODE: assert property (m [*2] |-> !din_out.level[0]) else $error("mode");
  AST_POL: assert property ((!m && $stable(p)) [*4] |-> din_out.level[0] == ($past(digital_input_nine, 3) ^ p))
    else $error("pol");
  AST_EDGE: assert property ((m && $stable({p, e})) [*5] ##0 din_out.latch[0]
    |-> ($past(digital_input_nine ^ p, 3) ^ e) && !($past(digital_input_nine ^ p, 4) ^ e)) else $error("edge");
  cover property (din_out.latch[0]);
  cover property (din_out.latch[1]);
  cover property (din_out.level[1]);
endmodule // dicfg_monitor
bind dicfg_top dicfg_monitor i_mon (.clk(clk), .sys_rst(sys_rst), .bus_req(bus_req), .rdata(rdata),
  .digital_input_nine(digital_input_nine), .digital_input_ten(digital_input_ten), .din_out(din_out));

// [tb/dicfg_field.sv]
// Field wiring model for inputs nine and ten
`timescale 1ns/10ps
module dicfg_field (
  input wire logic [1:0] want,
  output logic digital_input_nine,
  output logic digital_input_ten
);
  // Plain contacts, level only
  assign {digital_input_ten, digital_input_nine} = want;
endmodule // dicfg_field

// [tb/tb_top.sv]
// Testbench of the input configuration block
`timescale 1ns/10ps
module tb_top;
  import dicfg_pkg::*;
  logic clk = 0, sys_rst = 1, in9, in10;
  logic [1:0] want = 2'b00;
  dicfg_req_t bus_req = '0;
  logic [15:0] rdata;
  dicfg_out_t din_out;
  int error_cnt = 0, n_checks = 0;
  dicfg_top i_dut (.clk(clk), .sys_rst(sys_rst), .bus_req(bus_req), .rdata(rdata),
    .digital_input_nine(in9), .digital_input_ten(in10), .din_out(din_out));
  dicfg_field i_field (.want(want), .digital_input_nine(in9), .digital_input_ten(in10));
  initial forever #12.5 clk = ~clk;
  task cmp(string n, logic [15:0] x, logic [15:0] g);
    n_checks++;
    if (g !== x) begin
      error_cnt++;
      $display("wrong value %s exp %h got %h", n, x, g);
    end
  endtask
  task wr(logic [3:0] a, logic [15:0] d);
    @(posedge clk) bus_req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk) bus_req.wr <= 1'b0;
  endtask
  task rd(logic [3:0] a, logic [15:0] x);
    @(posedge clk) bus_req <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge clk) bus_req.rd <= 1'b0;
    #1 cmp("rdata", x, rdata);
  endtask
  task t_reset;
    for (int a = 0; a < 5; a++) rd(a[3:0], 16'h0000);
    rd(4'hf, 16'h0000);
  endtask
  task t_plain;
    @(posedge clk) want <= 2'b01;
    repeat (4) @(posedge clk);
    rd(4'h4, 16'h0001);
    wr(4'h0, 16'h0001);
    wr(4'h2, 16'h0001);
    repeat (4) @(posedge clk);
    rd(4'h4, 16'h0002);
    wr(4'h0, 16'h0000);
    wr(4'h2, 16'h0000);
    @(posedge clk) want <= 2'b00;
    repeat (4) @(posedge clk);
  endtask
  // One edge per call, so exactly one pulse
  task t_latch(logic [3:0] a, logic [15:0] d, logic [1:0] w, int b);
    int c;
    c = 0;
    wr(a, d);
    repeat (2) @(posedge clk);
    @(posedge clk) want <= w;
    repeat (8) begin
      @(posedge clk);
      #1 if (din_out.latch[b] === 1'b1) c++;
    end
    cmp("pulses", 16'h0001, 16'(c));
    cmp("level", 16'h0000, 16'(din_out.level[b]));
  endtask
  task conclude;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset;
    t_plain;
    t_latch(4'h1, 16'h0001, 2'b01, 0);
    t_latch(4'h1, 16'h0011, 2'b00, 0);
    t_latch(4'h3, 16'h0001, 2'b10, 1);
    t_latch(4'h3, 16'h0011, 2'b00, 1);
    conclude;
  end
endmodule // tb_top
